// ==== logic/rfid_protocol_config_timers.sv ====
// Protocol select, modulation pulse length and no-response timer registers with their timers.
// Functional notes
// - Protocol bit 7 set means responses carry no CRC; clear means CRC checked.
// - Protocol bit 6 picks direct mode zero (0) or direct mode one (1).
// - Protocol bit 0 picks one-of-four (0) or one-of-256 (1) pulse position coding.
// - Codes 0-1 give single subcarrier 6.62 kbps; codes 2-3 give 26.48 kbps.
// - Codes 4-5 give double subcarrier 6.67 kbps; codes 6-7 give 26.69 kbps.
// - Protocol register resets to 0x02: high rate, one subcarrier, one-of-four.
// - Pulse override resets to 0x00 and is preset on each protocol write.
// - A zero pulse override leaves pulse length to the selected protocol.
// - A nonzero override makes the pulse last value times 73.7 ns.
// - Protocol default modulation pulse is 9.44 us.
// - No response within the timeout raises the no-response interrupt flag.
// - Timeout equals register value times 37.76 us.
// - The timeout starts at the end of the transmitted end-of-frame.
// - No-response register resets to 0x0E and is preset on protocol writes.
// - Protocol write presets 755 us for high rate, 1812 us for low rate.
`timescale 1ns/1ps
`include "rfid_cfg.svh"

module rfid_protocol_config_timers (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [`DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic mod_req,
  input wire logic tx_eof_done,
  input wire logic rx_start,
  input wire logic no_resp_clear,
  output logic mod_pulse,
  output logic no_resp_irq,
  output logic no_resp_event,
  output logic rx_crc_absent,
  output logic direct_mode_one,
  output logic coding_256,
  output logic high_rate,
  output logic double_subcarrier
);

  rfid_pkg::top_state_t st;
  rfid_pkg::top_state_t next_st;

  logic pulse_busy;
  logic nr_done;
  // Phase accumulator sum before the wrap.
  logic [`ACC_W-1:0] acc_sum;
  logic [`DATA_W-1:0] pulse_len;
  logic [`DATA_W-1:0] silence_timeout;

  assign pulse_len = st.pulse;
  assign silence_timeout = st.noresp;

  always_comb begin
    next_st = st;

    // Average rate is exactly the carrier; single ticks jitter by one system clock.
    acc_sum = st.acc + `ACC_INC;
    if (acc_sum >= `ACC_MOD) begin
      next_st.carrier_tick = 1'b1;
      next_st.acc = acc_sum - `ACC_MOD;
    end else begin
      next_st.carrier_tick = 1'b0;
      next_st.acc = acc_sum;
    end

    // A protocol write also reloads both timing registers, so a host that changes
    // protocol loses any override it set before and must write it again afterwards.
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_PROTO: begin
          next_st.proto = reg_wdata;
          next_st.pulse = `RST_PULSE;
          if (reg_wdata[`BIT_HIGH_RATE]) begin
            next_st.noresp = `DATA_W'(`NR_PRESET_HIGH);
          end else begin
            next_st.noresp = `DATA_W'(`NR_PRESET_LOW);
          end
        end
        `ADDR_PULSE: begin
          next_st.pulse = reg_wdata;
        end
        `ADDR_NORESP: begin
          next_st.noresp = reg_wdata;
        end
        default: begin
          // Writes to unmapped addresses are dropped.
          next_st.proto = st.proto;
        end
      endcase
    end

    // Read data is zero outside its valid cycle, so a late sample never shows a register.
    next_st.rvalid = reg_rd;
    next_st.rdata = `ZERO_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_PROTO: begin
          next_st.rdata = st.proto;
        end
        `ADDR_PULSE: begin
          next_st.rdata = pulse_len;
        end
        `ADDR_NORESP: begin
          next_st.rdata = silence_timeout;
        end
        default: begin
          next_st.rdata = `ZERO_BYTE;
        end
      endcase
    end

    // A request that arrives while a pulse is running is ignored, not restarted.
    next_st.pulse_start = 1'b0;
    if (mod_req && !pulse_busy && !st.pulse_start) begin
      next_st.pulse_start = 1'b1;
    end

    // The length is worked out every cycle and handed over with the start strobe.
    if (st.pulse == `ZERO_BYTE) begin
      next_st.pulse_load = `TMR_W'(`DEF_PULSE_CYC);
    end else begin
      next_st.pulse_load = `TMR_W'(st.pulse) * `TMR_W'(`PULSE_STEP_CYC);
    end

    // The load is taken from the register at start, so a later write affects only
    // the next frame, never a wait that is already running.
    next_st.nr_start = 1'b0;
    next_st.nr_stop = 1'b0;
    next_st.no_resp_event = 1'b0;
    next_st.nr_load = `TMR_W'(st.noresp) * `TMR_W'(`NR_STEP_CYC);
    case (st.nr_state)
      rfid_pkg::NR_IDLE: begin
        // A zero timeout register leaves the timer off.
        if (tx_eof_done && (st.noresp != `ZERO_BYTE)) begin
          next_st.nr_start = 1'b1;
          next_st.nr_state = rfid_pkg::NR_WAIT;
        end
      end
      rfid_pkg::NR_WAIT: begin
        // A response start wins even in the cycle in which the timer runs out.
        if (rx_start) begin
          next_st.nr_stop = 1'b1;
          next_st.nr_state = rfid_pkg::NR_IDLE;
        end else if (nr_done) begin
          next_st.no_resp_event = 1'b1;
          next_st.nr_state = rfid_pkg::NR_IDLE;
        end
      end
      default: begin
        next_st.nr_state = rfid_pkg::NR_IDLE;
      end
    endcase

    // Set wins over a clear that lands in the same cycle.
    if (no_resp_clear) begin
      next_st.no_resp_irq = 1'b0;
    end
    if (next_st.no_resp_event) begin
      next_st.no_resp_irq = 1'b1;
    end
  end

  // Only constants load here; the protocol bits come up in the default reader mode.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.proto <= `RST_PROTO;
      st.pulse <= `RST_PULSE;
      st.noresp <= `RST_NORESP;
      st.nr_state <= rfid_pkg::NR_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Both timers count the same carrier tick, so their lengths stay in step.
  // The modulation pulse is never cut short, so its stop input is held low.
  carrier_timer u_pulse_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(st.carrier_tick),
    .start(st.pulse_start),
    .stop(1'b0),
    .load(st.pulse_load),
    .busy(pulse_busy),
    .done()
  );

  // The wait state machine already knows when a wait runs, so busy is not needed.
  // The timer is stopped as soon as a card answers.
  carrier_timer u_silence_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(st.carrier_tick),
    .start(st.nr_start),
    .stop(st.nr_stop),
    .load(st.nr_load),
    .busy(),
    .done(nr_done)
  );

  // Every output is a register bit or a timer flop, so none of them glitches;
  // the mode bits follow the protocol register one cycle after the write.
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign mod_pulse = pulse_busy;
  assign no_resp_irq = st.no_resp_irq;
  assign no_resp_event = st.no_resp_event;
  assign rx_crc_absent = st.proto[`BIT_RX_CRC_N];
  assign direct_mode_one = st.proto[`BIT_DIR_MODE];
  assign coding_256 = st.proto[`BIT_CODING];
  assign high_rate = st.proto[`BIT_HIGH_RATE];
  assign double_subcarrier = st.proto[`BIT_DOUBLE_SC];

endmodule

// ==== logic/rfid_cfg.svh ====
// Register map, reset values, field positions and timing constants of the protocol block.
`ifndef RFID_CFG_SVH
`define RFID_CFG_SVH

`define ADDR_W 5
`define DATA_W 8
`define ADDR_PROTO 5'h01
`define ADDR_PULSE 5'h06
`define ADDR_NORESP 5'h07

`define RST_PROTO 8'h02
`define RST_PULSE 8'h00
`define RST_NORESP 8'h0E
`define ZERO_BYTE 8'h00

`define BIT_RX_CRC_N 7
`define BIT_DIR_MODE 6
`define BIT_RFID 5
`define BIT_DOUBLE_SC 2
`define BIT_HIGH_RATE 1
`define BIT_CODING 0

// Carrier rate derived from the 100 MHz system clock by a phase accumulator.
`define CLK_KHZ 100000
`define CARRIER_KHZ 13560
`define ACC_W 17
`define ACC_MOD 17'h1_86A0
`define ACC_INC 17'h0_34F8

// Times in their printed units; carrier-tick counts derived from them.
`define PULSE_STEP_PS 73700
`define PULSE_STEP_CYC ((`PULSE_STEP_PS * `CARRIER_KHZ + 500000000) / 1000000000)
`define DEF_PULSE_NS 9440
`define DEF_PULSE_CYC ((`DEF_PULSE_NS * `CARRIER_KHZ + 500000) / 1000000)
`define NR_STEP_NS 37760
`define NR_STEP_CYC ((`NR_STEP_NS * `CARRIER_KHZ + 500000) / 1000000)
`define NR_HIGH_US 755
`define NR_LOW_US 1812
`define NR_PRESET_HIGH ((`NR_HIGH_US * 1000 + `NR_STEP_NS / 2) / `NR_STEP_NS)
`define NR_PRESET_LOW ((`NR_LOW_US * 1000 + `NR_STEP_NS / 2) / `NR_STEP_NS)

`define TMR_W 17

`endif

// ==== logic/rfid_pkg.sv ====
// Types shared by the protocol configuration block and its carrier timer.
`include "rfid_cfg.svh"

package rfid_pkg;

  typedef enum logic [0:0] {
    NR_IDLE,
    NR_WAIT
  } nr_state_t;

  typedef struct packed {
    logic [`TMR_W-1:0] count;
    logic busy;
    logic done;
  } timer_state_t;

  typedef struct packed {
    logic [`ACC_W-1:0] acc;
    logic carrier_tick;
    logic [`DATA_W-1:0] proto;
    logic [`DATA_W-1:0] pulse;
    logic [`DATA_W-1:0] noresp;
    logic [`DATA_W-1:0] rdata;
    logic rvalid;
    nr_state_t nr_state;
    logic no_resp_irq;
    logic no_resp_event;
    logic pulse_start;
    logic [`TMR_W-1:0] pulse_load;
    logic nr_start;
    logic nr_stop;
    logic [`TMR_W-1:0] nr_load;
  } top_state_t;

endpackage

// ==== logic/carrier_timer.sv ====
// Down-counter that runs for a loaded number of carrier ticks.
`timescale 1ns/1ps
`include "rfid_cfg.svh"

module carrier_timer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [`TMR_W-1:0] load,
  output logic busy,
  output logic done
);

  rfid_pkg::timer_state_t st;
  rfid_pkg::timer_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.count = load;
      next_st.busy = (load != `TMR_W'(0));
    end else if (stop) begin
      next_st.busy = 1'b0;
    end else if (st.busy && tick) begin
      // Steps are whole carrier ticks; the first one after start can be shorter than a full tick period.
      next_st.count = st.count - `TMR_W'(1);
      if (st.count == `TMR_W'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.done;

endmodule

// ==== test/host_model.sv ====
// Host side model driving the register strobe port.
`timescale 1ns/1ps
`include "rfid_cfg.svh"
module host_model (
  input wire logic mclk,
  output logic [`ADDR_W-1:0] reg_addr,
  output logic [`DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [`DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 5'h1F;
    reg_wdata = 8'hA5;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle address and data are inverted so a stale value never looks valid.
  // Protocol writes always go out with bit 5 (BIT_RFID) cleared.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= (a == `ADDR_PROTO) ? (d & 8'hDF) : d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

// ==== test/rfid_cfg_checker.sv ====
// Concurrent checks on the protocol configuration block ports.
`timescale 1ns/1ps
`include "rfid_cfg.svh"
module rfid_cfg_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [`DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic mod_req,
  input wire logic no_resp_clear,
  input wire logic mod_pulse,
  input wire logic no_resp_irq,
  input wire logic no_resp_event,
  input wire logic rx_crc_absent,
  input wire logic direct_mode_one,
  input wire logic coding_256,
  input wire logic high_rate,
  input wire logic double_subcarrier
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic pw;
  assign pw = reg_wr && reg_addr == `ADDR_PROTO;
  a_crc_bit: assert property (pw |=> ##1 rx_crc_absent == $past(reg_wdata[7], 2))
    else $error("crc select wrong");
  a_dir_bit: assert property (pw |=> ##1 direct_mode_one == $past(reg_wdata[6], 2))
    else $error("direct mode type wrong");
  a_coding_bit: assert property (pw |=> ##1 coding_256 == $past(reg_wdata[0], 2))
    else $error("coding wrong");
  a_rate_bit: assert property (pw |=> ##1 high_rate == $past(reg_wdata[1], 2))
    else $error("rate wrong");
  a_double_sc: assert property (pw |=> ##1 double_subcarrier == $past(reg_wdata[2], 2))
    else $error("subcarrier wrong");
  a_pulse_start: assert property ($rose(mod_pulse) |-> $past(mod_req, 2))
    else $error("pulse without request");
  a_event_flag: assert property (no_resp_event |-> no_resp_irq)
    else $error("event without flag");
  a_flag_sticky: assert property (no_resp_irq && !no_resp_clear |=> no_resp_irq)
    else $error("flag dropped");
  a_event_single: assert property (no_resp_event |=> !no_resp_event)
    else $error("event too long");
  a_irq_clear: assert property (no_resp_clear |=> !no_resp_irq || no_resp_event)
    else $error("flag not cleared");
endmodule
bind rfid_protocol_config_timers rfid_cfg_checker rfid_cfg_checker_inst (.mclk, .rst_n,
  .reg_addr, .reg_wdata, .reg_wr, .mod_req, .no_resp_clear, .mod_pulse, .no_resp_irq,
  .no_resp_event, .rx_crc_absent, .direct_mode_one, .coding_256, .high_rate,
  .double_subcarrier);

// ==== test/rfid_protocol_config_timers_test.sv ====
// Self-checking bench for the protocol configuration and timer block.
`timescale 1ns/1ps
`include "rfid_cfg.svh"
module rfid_protocol_config_timers_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic mod_req = 1'b0;
  logic tx_eof_done = 1'b0;
  logic rx_start = 1'b0;
  logic no_resp_clear = 1'b0;
  logic [`ADDR_W-1:0] reg_addr;
  logic [`DATA_W-1:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, mod_pulse, no_resp_irq, no_resp_event;
  logic rx_crc_absent, direct_mode_one, coding_256, high_rate, double_subcarrier;
  int err_total = 0;
  int tests_run = 0;
  int n;
  logic [7:0] v;
  always #5 mclk = ~mclk;
  host_model host_model_inst (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid);
  rfid_protocol_config_timers rfid_protocol_config_timers_inst (.mclk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .mod_req, .tx_eof_done, .rx_start,
    .no_resp_clear, .mod_pulse, .no_resp_irq, .no_resp_event, .rx_crc_absent,
    .direct_mode_one, .coding_256, .high_rate, .double_subcarrier);
  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp, input int tol);
    chk(8'(got >= exp - tol && got <= exp + tol), 8'h01);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_model_inst.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask
  function automatic logic [7:0] outs();
    return {3'b000, rx_crc_absent, direct_mode_one, double_subcarrier, high_rate, coding_256};
  endfunction
  // Flag selector: 0 pulse, 1 timeout event, anything else the sticky flag.
  function automatic logic pick(input int which);
    case (which)
      0: return mod_pulse;
      1: return no_resp_event;
      default: return no_resp_irq;
    endcase
  endfunction
  // Counts cycles until a flag goes high; the bound stands in for a hang.
  task automatic wait_hi(input int which, input int lim, output int c);
    c = 0;
    while (pick(which) !== 1'b1 && c < lim) begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask
  task automatic pulse(output int len);
    @(posedge mclk) mod_req <= 1'b1;
    @(posedge mclk) mod_req <= 1'b0;
    wait_hi(0, 4, len);
    len = 0;
    while (mod_pulse === 1'b1 && len < 3000) begin
      @(posedge mclk);
      #1;
      len++;
    end
  endtask
  // Strobe selector: 0 end of frame, 1 response start, anything else the clear.
  task automatic pulse_in(input int which);
    @(posedge mclk);
    case (which)
      0: tx_eof_done <= 1'b1;
      1: rx_start <= 1'b1;
      default: no_resp_clear <= 1'b1;
    endcase
    @(posedge mclk);
    tx_eof_done <= 1'b0;
    rx_start <= 1'b0;
    no_resp_clear <= 1'b0;
  endtask
  initial begin
    #900us;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(`ADDR_PROTO, 8'h02);
    chk(outs(), 8'h02);
    rdc(`ADDR_PULSE, 8'h00);
    rdc(`ADDR_NORESP, 8'h0E);
    rdc(5'h02, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], 3'b000, i[2:0]};
      host_model_inst.wr(`ADDR_PULSE, 8'h55);
      host_model_inst.wr(`ADDR_NORESP, 8'h77);
      host_model_inst.wr(`ADDR_PROTO, v);
      rdc(`ADDR_PROTO, v);
      chk(outs(), {3'b000, v[7:6], v[2:0]});
      rdc(`ADDR_PULSE, 8'h00);
      rdc(`ADDR_NORESP, v[1] ? 8'h14 : 8'h30);
    end
    host_model_inst.wr(`ADDR_PROTO, 8'h02);
    pulse(n);
    near(n, 940, 10);
    host_model_inst.wr(`ADDR_PULSE, 8'h0A);
    pulse(n);
    near(n, 70, 8);
    host_model_inst.wr(`ADDR_NORESP, 8'h01);
    pulse_in(0);
    wait_hi(1, 4500, n);
    near(n, 3777, 12);
    chk({7'h00, no_resp_irq}, 8'h01);
    pulse_in(2);
    #1 chk({7'h00, no_resp_irq}, 8'h00);
    pulse_in(0);
    repeat (100) @(posedge mclk);
    pulse_in(1);
    wait_hi(2, 4500, n);
    chk({7'h00, no_resp_irq}, 8'h00);
    wrap_up();
  end
endmodule
